// ---- src/sld_pkg.sv ----
// constants for the serial latched sink driver
// Function
// - each shift clock rising edge shifts serial input in, advancing contents one stage.
// - while transfer strobe is high, shift register copies into output latches.
// - current select low gives full current, high gives half current.
// - blanking low lets drivers follow latches; high forces all drivers off.
// - second cascade output updates on shift clock falling edge.
// - first cascade output updates on shift clock rising edge.
// - eight sink driver outputs, each controlled by its own latch bit.
// - latches stay transparent while strobe stays high; later shifts reach them.
// - latch contents never depend on the blanking input.
package sld_pkg;
    localparam int          SLD_WIDTH      = 8;
    localparam int          SLD_SYNC_DEPTH = 3;
    localparam logic [7:0]  SLD_RST_BYTE   = 8'h00;
    localparam logic        SLD_CUR_FULL   = 1'b0;
    localparam logic        SLD_CUR_HALF   = 1'b1;
endpackage : sld_pkg

// ---- src/sld_sync.sv ----
// three-stage input synchroniser with agreement check
`timescale 1ns/1ps
`default_nettype none
module sld_sync
    import sld_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout,
    output logic      rise,
    output logic      fall
);
    logic [2:0] s_q;
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            s_q <= 3'h0;
        else
            s_q <= {s_q[1:0], din};
    end
    // stage 0 is read only by stage 1
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            dout <= 1'b0;
        else if (s_q[1] == s_q[2])
            dout <= s_q[2];
    end
    assign rise = (s_q[1] == s_q[2]) && s_q[2] && !dout;
    assign fall = (s_q[1] == s_q[2]) && !s_q[2] && dout;
endmodule : sld_sync
`default_nettype wire

// ---- src/sld_top.sv ----
// serial-input latched sink driver control logic
`timescale 1ns/1ps
`default_nettype none
module sld_top
    import sld_pkg::*;
#(
    parameter int WIDTH = SLD_WIDTH
)
(
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             shift_clk,
    input  wire logic             shift_din,
    input  wire logic             xfer_strobe,
    input  wire logic             cur_half,
    input  wire logic             blank_n_en,
    output logic [WIDTH-1:0]      sink_drivers,
    output logic                  drive_half,
    output logic                  cascade_out_rise,
    output logic                  cascade_out_fall
);
    // synchronised copies of the pins and their edge strobes
    logic             clk_s;
    logic             clk_rise;
    logic             clk_fall;
    logic             din_s;
    logic             stb_s;
    logic             half_s;
    logic             blank_s;
    logic [WIDTH-1:0] shreg_q;
    logic [WIDTH-1:0] latch_q;
    // data pin must be sampled in step with the clock edge
    logic             din_d1_q;

    // every pin other than ref_clk and nrst passes the three-flop synchroniser before use
    sld_sync u_clk
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .din     (shift_clk),
        .dout    (clk_s),
        .rise    (clk_rise),
        .fall    (clk_fall)
    );

    sld_sync u_stb
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .din     (xfer_strobe),
        .dout    (stb_s),
        .rise    (),
        .fall    ()
    );

    sld_sync u_half
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .din     (cur_half),
        .dout    (half_s),
        .rise    (),
        .fall    ()
    );

    sld_sync u_blk
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .din     (blank_n_en),
        .dout    (blank_s),
        .rise    (),
        .fall    ()
    );

    sld_sync u_din
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .din     (shift_din),
        .dout    (din_s),
        .rise    (),
        .fall    ()
    );

    // data is taken as seen one edge before the clock edge resolves (setup)
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            din_d1_q <= 1'b0;
        end
        else
        begin
            din_d1_q <= din_s;
        end
    end

    // pin clock pulses shorter than the synchroniser can resolve are lost
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            shreg_q <= WIDTH'(SLD_RST_BYTE);
        else if (clk_rise)
            shreg_q <= {shreg_q[WIDTH-2:0], din_d1_q};
    end

    // transparent while strobe high; blanking never touches latches
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            latch_q <= WIDTH'(SLD_RST_BYTE);
        else if (stb_s)
            latch_q <= shreg_q;
    end

    // blanking gates outputs only, so unblanking shows the stored pattern
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            sink_drivers <= '0;
        else if (blank_s)
            sink_drivers <= '0;
        else
            sink_drivers <= latch_q;
    end

    // digital select for the analog current stage
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            drive_half <= SLD_CUR_FULL;
        else
            drive_half <= (half_s == SLD_CUR_HALF);
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            cascade_out_rise <= 1'b0;
        else if (clk_rise)
            cascade_out_rise <= shreg_q[WIDTH-2];
    end

    // half a clock later than the rise copy, for chains with skewed clocks
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            cascade_out_fall <= 1'b0;
        else if (clk_fall)
            cascade_out_fall <= shreg_q[WIDTH-1];
    end

    a_shift_moves: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_rise |=> shreg_q == {$past(shreg_q[WIDTH-2:0]), $past(din_d1_q)})
        else $error("shift register did not advance");
    a_latch_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
        stb_s |=> latch_q == $past(shreg_q))
        else $error("latch not transparent");
    a_latch_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !stb_s |=> $stable(latch_q))
        else $error("latch changed while closed");
    a_blank_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        blank_s |=> sink_drivers == '0)
        else $error("drivers on while blanked");
    a_drive_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
        !blank_s |=> sink_drivers == $past(latch_q))
        else $error("drivers not following latch");
    a_half_cur: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 drive_half == $past(half_s))
        else $error("current select mismatch");
    a_casc_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_rise |=> cascade_out_rise == shreg_q[WIDTH-1])
        else $error("rise cascade wrong");
    a_casc_fall: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_fall |=> cascade_out_fall == shreg_q[WIDTH-1])
        else $error("fall cascade wrong");
    a_stb_through: assert property (@(posedge ref_clk) disable iff (!nrst)
        stb_s && clk_rise ##1 stb_s |=> latch_q == $past(shreg_q))
        else $error("later shift did not reach latch");

    // shifting only on a resolved clock rise
    a_clk_level: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_rise |=> clk_s)
        else $error("clock rise not followed by high level");

    a_shift_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !clk_rise |=> $stable(shreg_q))
        else $error("shift register moved without clock rise");

    // latches change only through the strobe
    a_latch_from: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(latch_q) |-> $past(stb_s))
        else $error("latch changed without strobe");

    a_blank_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
        blank_s && !stb_s |=> $stable(latch_q))
        else $error("blanking disturbed latch");

    a_latch_blank_stb: assert property (@(posedge ref_clk) disable iff (!nrst)
        blank_s && stb_s |=> latch_q == $past(shreg_q))
        else $error("blanking stopped latch transfer");

    // current select levels
    a_half_full: assert property (@(posedge ref_clk) disable iff (!nrst)
        !half_s |=> drive_half == SLD_CUR_FULL)
        else $error("full current not selected");

    a_half_half: assert property (@(posedge ref_clk) disable iff (!nrst)
        half_s |=> drive_half == SLD_CUR_HALF)
        else $error("half current not selected");

    // cascade outputs move only on their own edge
    a_casc_rise_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !clk_rise |=> $stable(cascade_out_rise))
        else $error("rise cascade moved off its edge");

    a_casc_fall_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !clk_fall |=> $stable(cascade_out_fall))
        else $error("fall cascade moved off its edge");

    a_casc_agree: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_fall |=> cascade_out_fall == cascade_out_rise)
        else $error("cascade outputs disagree");

    a_casc_fall_clk: assert property (@(posedge ref_clk) disable iff (!nrst)
        clk_fall |=> !clk_s)
        else $error("fall cascade update without clock low");
endmodule : sld_top
`default_nettype wire

// ---- tb/sld_host.sv ----
// host model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module sld_host (
    input  wire logic ref_clk,
    output logic      shift_clk,
    output logic      shift_din,
    output logic      xfer_strobe
);
    initial
    begin
        shift_clk   = 1'b0;
        shift_din   = 1'b0;
        xfer_strobe = 1'b0;
    end
    // msb first, phases of 5 cycles to clear the 4-cycle minimum
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            shift_din = b[i];
            repeat (5) @(posedge ref_clk) #1;
            shift_clk = 1'b1;
            repeat (5) @(posedge ref_clk) #1;
            shift_clk = 1'b0;
        end
    endtask : send_byte
    task automatic strobe(input logic v);
        xfer_strobe = v;
    endtask : strobe
endmodule : sld_host
`default_nettype wire

// ---- tb/serial_latched_sink_driver_ctrl_tb.sv ----
// self-checking bench for the sink driver control logic
`timescale 1ns/1ps
`default_nettype none
module serial_latched_sink_driver_ctrl_tb;
    logic       ref_clk    = 1'b0;
    logic       nrst       = 1'b0;
    logic       cur_half   = 1'b0;
    logic       blank_n_en = 1'b0;
    logic       shift_clk, shift_din, xfer_strobe, drive_half, c_rise, c_fall;
    logic [7:0] sink_drivers;
    int         num_errors = 0;
    int         n_compared = 0;
    always #5 ref_clk = ~ref_clk;
    sld_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .shift_clk(shift_clk),
        .shift_din(shift_din), .xfer_strobe(xfer_strobe), .cur_half(cur_half),
        .blank_n_en(blank_n_en), .sink_drivers(sink_drivers), .drive_half(drive_half),
        .cascade_out_rise(c_rise), .cascade_out_fall(c_fall));
    sld_host u_host (.ref_clk(ref_clk), .shift_clk(shift_clk), .shift_din(shift_din),
        .xfer_strobe(xfer_strobe));
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk) #1;
    endtask : wait_cyc
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic t_load();
        u_host.send_byte(8'ha5);
        u_host.strobe(1'b1);
        wait_cyc(10);
        u_host.strobe(1'b0);
        wait_cyc(10);
        check(sink_drivers, 8'ha5);
        check({7'h00, c_rise}, 8'h01);
        check({7'h00, c_fall}, 8'h01);
        blank_n_en = 1'b1;
        wait_cyc(10);
        check(sink_drivers, 8'h00);
        blank_n_en = 1'b0;
        wait_cyc(10);
        check(sink_drivers, 8'ha5);
        for (int i = 1; i >= 0; i--)
        begin
            cur_half = i[0];
            wait_cyc(10);
            check({7'h00, drive_half}, {7'h00, i[0]});
        end
        $display("test load done");
    endtask : t_load
    // latches open while shifting, outputs blanked meanwhile
    task automatic t_transparent();
        blank_n_en = 1'b1;
        u_host.strobe(1'b1);
        u_host.send_byte(8'h3c);
        wait_cyc(10);
        check(sink_drivers, 8'h00);
        check({7'h00, c_rise}, 8'h00);
        blank_n_en = 1'b0;
        wait_cyc(10);
        check(sink_drivers, 8'h3c);
        u_host.strobe(1'b0);
        $display("test transparent done");
    endtask : t_transparent
    // mid-run reset clears every output and the stored pattern
    task automatic t_reset();
        u_host.send_byte(8'h81);
        u_host.strobe(1'b1);
        wait_cyc(10);
        u_host.strobe(1'b0);
        cur_half = 1'b1;
        wait_cyc(10);
        check(sink_drivers, 8'h81);
        nrst = 1'b0;
        wait_cyc(2);
        check({5'h00, drive_half, c_rise, c_fall}, 8'h00);
        check(sink_drivers, 8'h00);
        cur_half = 1'b0;
        nrst = 1'b1;
        wait_cyc(4);
        u_host.strobe(1'b1);
        wait_cyc(10);
        u_host.strobe(1'b0);
        wait_cyc(4);
        check(sink_drivers, 8'h00);
        $display("test reset done");
    endtask : t_reset
    initial
    begin
        wait_cyc(4);
        check(sink_drivers, 8'h00);
        nrst = 1'b1;
        wait_cyc(4);
        t_load();
        t_transparent();
        t_reset();
        close_out();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        close_out();
    end
endmodule : serial_latched_sink_driver_ctrl_tb
`default_nettype wire
